// ### decu_counter.sv
// decu_counter: occurrence counter for one channel
// assumes: hit is a one-cycle qualified match, count loaded while idle
`timescale 1ns/1ps
module decu_counter
  import decu_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk,     // processor clock
  input  wire logic         nrst,    // sync reset, active low
  input  wire logic         cnt_en,  // count qualifier enabled
  input  wire logic [W-1:0] cnt_num, // occurrences needed
  input  wire logic         hit,     // other qualifiers matched
  output logic              fire     // match after count reached
);

  logic [W-1:0] seen;

  // =====================================
  // occurrence tally
  always_ff @(posedge clk) begin
    if (!nrst || !cnt_en) begin
      seen <= W'(0);
    end else if (hit) begin
      if (seen + W'(1) >= cnt_num) begin
        seen <= W'(0);
      end else begin
        seen <= seen + W'(1);
      end
    end
  end

  // fire on the nth occurrence; zero or one count fires at once
  assign fire = hit && (!cnt_en || (seen + W'(1) >= cnt_num));

endmodule

// ### decu_cpu_model.sv
// decu_cpu_model: processor activity as seen by the event unit
// assumes: op called from the bench; changes on falling clk
`timescale 1ns/1ps
module decu_cpu_model
  import decu_pkg::*;
(
  input  wire logic          clk,                  // clock
  output logic               cpu_acc,              // cpu access
  output logic [ADDR_W-1:0]  cpu_addr,             // cpu address
  output logic [DATA_W-1:0]  cpu_data,             // cpu data
  output logic               cpu_write,            // write
  output logic               ifetch,               // executed
  output logic [ADDR_W-1:0]  pc,                   // program counter
  output logic               sys_acc,              // sys access
  output logic [ADDR_W-1:0]  sys_addr,             // sys address
  output logic [DATA_W-1:0]  sys_data,             // sys data
  output logic               tlb_load_instruction, // tlb load
  output logic               branch,               // branch
  output logic [ADDR_W-1:0]  branch_src,           // source
  output logic [ADDR_W-1:0]  branch_dst,           // target
  output logic               xbus_acc,             // x bus access
  output logic [ADDR_W-1:0]  xbus_addr,            // x bus address
  output logic               ybus_acc,             // y bus access
  output logic [ADDR_W-1:0]  ybus_addr             // y bus address
);
  initial begin
    {cpu_acc, ifetch, sys_acc, tlb_load_instruction, branch, xbus_acc, ybus_acc, cpu_write} = 8'h00;
    {cpu_addr, pc, sys_addr, branch_src, branch_dst, xbus_addr, ybus_addr, cpu_data, sys_data} = '0;
  end

  // one active cycle: 0 cpu, 1 fetch, 2 sys, 3 tlb load, 4 branch, 5 x bus, 6 y bus
  task automatic op(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic wr);
    @(negedge clk);
    {cpu_acc, ifetch, sys_acc, tlb_load_instruction, branch, xbus_acc, ybus_acc} = 7'h40 >> k;
    {cpu_addr, pc, sys_addr, branch_src, branch_dst, xbus_addr, ybus_addr} = {7{a}};
    {cpu_data, sys_data} = {2{d}};
    cpu_write = wr;
    @(negedge clk);
    {cpu_acc, ifetch, sys_acc, tlb_load_instruction, branch, xbus_acc, ybus_acc} = 7'h00;
    // released buses show no stale value
    {cpu_addr, pc, sys_addr, branch_src, branch_dst, xbus_addr, ybus_addr} = {7{~a}};
    {cpu_data, sys_data} = {2{~d}};
    cpu_write = ~wr;
  endtask
endmodule

// ### decu_pkg.sv
// decu_pkg: constants and types for the debug event condition unit
// assumes: included before all decu design files
package decu_pkg;

  // =====================================
  // channel map
  localparam int NUM_CH      = 12;
  localparam int CH_TLB      = 6;   // zero-based index of channel seven
  localparam int CH_BRANCH   = 11;  // zero-based index of channel twelve
  localparam int CH_SYS      = 7;   // zero-based index of channel eight
  localparam int CH_COUNT    = 1;   // only channel two counts occurrences
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int CNT_W       = 16;

  // =====================================
  // action encodings
  typedef enum logic [1:0] {
    DECU_ACT_BREAK      = 2'h0,
    DECU_ACT_TRACE      = 2'h1,
    DECU_ACT_PERF_START = 2'h2,
    DECU_ACT_PERF_END   = 2'h3
  } decu_action_t;

  // access size encodings
  typedef enum logic [1:0] {
    DECU_SZ_BYTE = 2'h0,
    DECU_SZ_WORD = 2'h1,
    DECU_SZ_LONG = 2'h2
  } decu_size_t;

  // qualifier enable bit positions within a channel's enable field
  localparam int QE_ADDR   = 0;
  localparam int QE_DATA   = 1;
  localparam int QE_BUS    = 2;
  localparam int QE_RW     = 3;
  localparam int QE_WIN    = 4;
  localparam int QE_SYS    = 5;
  localparam int QE_TLB    = 6;
  localparam int QE_BRANCH = 7;
  localparam int QE_W      = 8;

  // per-channel capability masks, bit per qualifier
  localparam logic [QE_W-1:0] CAP_ADDR_CH = 8'h0F;  // channels one to four
  localparam logic [QE_W-1:0] CAP_BUS_CH  = 8'h1C;  // channels five and six
  localparam logic [QE_W-1:0] CAP_TLB_CH  = 8'h40;  // channel seven
  localparam logic [QE_W-1:0] CAP_SYS_CH  = 8'h21;  // channel eight
  localparam logic [QE_W-1:0] CAP_BR_CH   = 8'h80;  // channel twelve
  localparam logic [QE_W-1:0] CAP_NONE    = 8'h00;

  // reset values
  localparam logic [QE_W-1:0] QE_RESET     = 8'h00;
  localparam logic            BR_TRACE_RST = 1'b1;
  localparam logic            SW_TRACE_RST = 1'b0;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;

  // byte-lane masks by size
  localparam logic [DATA_W-1:0] MASK_BYTE = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] MASK_WORD = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] MASK_LONG = 32'hFFFF_FFFF;

  // capability of a channel
  function automatic logic [QE_W-1:0] decu_cap(input int ch);
    if (ch < 4) begin
      decu_cap = CAP_ADDR_CH;
    end else if (ch == 4 || ch == 5) begin
      decu_cap = CAP_BUS_CH;
    end else if (ch == CH_TLB) begin
      decu_cap = CAP_TLB_CH;
    end else if (ch == CH_SYS) begin
      decu_cap = CAP_SYS_CH;
    end else if (ch == CH_BRANCH) begin
      decu_cap = CAP_BR_CH;
    end else begin
      decu_cap = CAP_NONE;
    end
  endfunction

  // channel may produce a trace action
  function automatic logic decu_can_trace(input int ch);
    decu_can_trace = (ch == 4) || (ch == 5) || (ch == CH_SYS) || (ch == CH_BRANCH);
  endfunction

  // size-masked data compare
  function automatic logic decu_data_eq(input logic [DATA_W-1:0] a,
                                        input logic [DATA_W-1:0] b,
                                        input decu_size_t sz);
    logic [DATA_W-1:0] m;
    m = MASK_LONG;
    if (sz == DECU_SZ_BYTE) begin
      m = MASK_BYTE;
    end else if (sz == DECU_SZ_WORD) begin
      m = MASK_WORD;
    end
    decu_data_eq = ((a ^ b) & m) == '0;
  endfunction

endpackage

// ### decu_top.sv
// decu_top: twelve-channel debug event condition unit plus software trace
// assumes: all bus observation inputs synchronous to clk, valid qualified
//
// Notes on behaviour
// - twelve channels plus a software trace channel
// - address channel: bus or PC equals value
// - data match at byte, word, longword size
// - bus state: data or X/Y address match
// - bus state honours read/write direction
// - window channel: access inside address range
// - system bus address or data match
// - break on TLB-load instruction execution
// - break after programmed number of occurrences
// - branch condition; branch trace enabled at reset
// - action: break, trace, perf start/end
// - software trace enable gates software entries
`timescale 1ns/1ps
module decu_top
  import decu_pkg::*;
#(
  parameter int N  = NUM_CH,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int CW = CNT_W
) (
  input  wire logic                clk,          // processor clock
  input  wire logic                nrst,         // sync reset, active low
  // observed processor activity
  input  wire logic                cpu_acc,      // cpu operand access valid
  input  wire logic [AW-1:0]       cpu_addr,     // cpu address bus
  input  wire logic [DW-1:0]       cpu_data,     // cpu data bus
  input  wire logic                cpu_write,    // access is a write
  input  wire logic                ifetch,       // instruction executed
  input  wire logic [AW-1:0]       pc,           // program counter
  input  wire logic                xbus_acc,     // X memory bus access valid
  input  wire logic [AW-1:0]       xbus_addr,    // X memory bus address
  input  wire logic                ybus_acc,     // Y memory bus access valid
  input  wire logic [AW-1:0]       ybus_addr,    // Y memory bus address
  input  wire logic                sys_acc,      // system bus access valid
  input  wire logic [AW-1:0]       sys_addr,     // system bus address
  input  wire logic [DW-1:0]       sys_data,     // system bus data
  input  wire logic                tlb_load_instruction, // TLB-load executed
  input  wire logic                branch,       // branch taken
  input  wire logic [AW-1:0]       branch_src,   // branch source address
  input  wire logic [AW-1:0]       branch_dst,   // branch target address
  input  wire logic                sw_trace_req, // software trace request
  input  wire logic [DW-1:0]       sw_trace_data,// software trace payload
  // per-channel configuration
  input  wire logic [N*QE_W-1:0]   ch_qual_en,   // qualifier enables
  input  wire logic [N*2-1:0]      ch_action,    // action select
  input  wire logic [N*AW-1:0]     ch_addr,      // compare address
  input  wire logic [N*AW-1:0]     ch_addr_hi,   // window high bound
  input  wire logic [N*DW-1:0]     ch_data,      // compare data
  input  wire logic [N*2-1:0]      ch_size,      // data compare size
  input  wire logic [N-1:0]        ch_rw_write,  // direction: 1 write
  input  wire logic [N-1:0]        ch_cnt_en,    // count qualifier enable
  input  wire logic [N*CW-1:0]     ch_cnt,       // count value
  input  wire logic                br_trace_dis, // branch trace off request
  input  wire logic                sw_trace_en,  // software trace enable
  // results
  output logic                     brk,          // break request pulse
  output logic [N-1:0]             brk_src,      // channels causing break
  output logic                     trace_vld,    // trace entry pulse
  output logic [N-1:0]             trace_src,    // channels traced
  output logic [AW-1:0]            trace_addr,   // traced address
  output logic [DW-1:0]            trace_data,   // traced data
  output logic                     trace_sw,     // entry is software trace
  output logic                     perf_start,   // measurement start pulse
  output logic                     perf_end,     // measurement end pulse
  output logic                     br_trace_on   // branch trace enabled
);

  logic [N-1:0]  chan_hit;
  logic [N-1:0]  chan_fire;
  logic [N-1:0]  next_brk_src;
  logic [N-1:0]  next_trace_src;
  logic          next_perf_start;
  logic          next_perf_end;
  logic [AW-1:0] next_taddr;
  logic [DW-1:0] next_tdata;

  // =====================================
  // branch trace enable state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      br_trace_on <= BR_TRACE_RST;
    end else begin
      br_trace_on <= !br_trace_dis;
    end
  end

  // =====================================
  // per-channel qualifiers
  for (genvar c = 0; c < N; c++) begin : g_ch
    logic [QE_W-1:0] qe;
    logic [AW-1:0]   ca;
    logic [DW-1:0]   cd;
    decu_size_t      sz;
    logic            win_hit;
    logic [QE_W-1:0] ok;
    logic            any_en;

    assign qe = ch_qual_en[c*QE_W +: QE_W] & decu_cap(c);
    assign ca = ch_addr[c*AW +: AW];
    assign cd = ch_data[c*DW +: DW];
    assign sz = decu_size_t'(ch_size[c*2 +: 2]);

    decu_window #(.AW(AW)) u_win (
      .addr (cpu_addr),
      .lo   (ca),
      .hi   (ch_addr_hi[c*AW +: AW]),
      .hit  (win_hit)
    );

    always_comb begin
      ok = '1;
      ok[QE_ADDR] = (cpu_acc && cpu_addr == ca) || (ifetch && pc == ca);
      ok[QE_DATA] = cpu_acc && decu_data_eq(cpu_data, cd, sz);
      ok[QE_BUS]  = (cpu_acc && decu_data_eq(cpu_data, cd, sz))
                    || (xbus_acc && xbus_addr == ca)
                    || (ybus_acc && ybus_addr == ca);
      ok[QE_RW]   = cpu_acc && (cpu_write == ch_rw_write[c]);
      ok[QE_WIN]  = cpu_acc && win_hit;
      ok[QE_SYS]  = sys_acc && (sys_addr == ca || decu_data_eq(sys_data, cd, DECU_SZ_LONG));
      ok[QE_TLB]  = tlb_load_instruction;
      ok[QE_BRANCH] = branch && (branch_src == ca || branch_dst == ca
                                 || ca == '0);
    end

    assign any_en = |qe;
    // all enabled qualifiers must match together
    assign chan_hit[c] = any_en && (&(ok | ~qe));

    decu_counter #(.W(CW)) u_cnt (
      .clk     (clk),
      .nrst    (nrst),
      .cnt_en  (ch_cnt_en[c] && c == CH_COUNT),
      .cnt_num (ch_cnt[c*CW +: CW]),
      .hit     (chan_hit[c]),
      .fire    (chan_fire[c])
    );
  end

  // =====================================
  // action routing
  always_comb begin
    decu_action_t act;
    act             = DECU_ACT_BREAK;
    next_brk_src    = '0;
    next_trace_src  = '0;
    next_perf_start = 1'b0;
    next_perf_end   = 1'b0;
    for (int c = 0; c < N; c++) begin
      act = decu_action_t'(ch_action[c*2 +: 2]);
      if (c == CH_TLB) begin
        act = DECU_ACT_BREAK;
      end
      if (chan_fire[c]) begin
        case (act)
          DECU_ACT_BREAK:      next_brk_src[c] = 1'b1;
          DECU_ACT_TRACE: begin
            if (decu_can_trace(c) && (c != CH_BRANCH || br_trace_on)) begin
              next_trace_src[c] = 1'b1;
            end
          end
          DECU_ACT_PERF_START: next_perf_start = 1'b1;
          DECU_ACT_PERF_END:   next_perf_end = 1'b1;
          default:             next_brk_src[c] = 1'b1;
        endcase
      end
    end
  end

  // trace payload: branch, system bus or cpu bus
  always_comb begin
    next_taddr = cpu_addr;
    next_tdata = cpu_data;
    if (next_trace_src[CH_BRANCH]) begin
      next_taddr = branch_src;
      next_tdata = branch_dst;
    end else if (next_trace_src[CH_SYS]) begin
      next_taddr = sys_addr;
      next_tdata = sys_data;
    end
  end

  // =====================================
  // break and performance outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      brk        <= 1'b0;
      brk_src    <= '0;
      perf_start <= 1'b0;
      perf_end   <= 1'b0;
    end else begin
      brk        <= |next_brk_src;
      brk_src    <= next_brk_src;
      perf_start <= next_perf_start;
      perf_end   <= next_perf_end;
    end
  end

  // =====================================
  // trace capture; channel entries take priority over software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trace_vld  <= 1'b0;
      trace_src  <= '0;
      trace_addr <= '0;
      trace_data <= '0;
      trace_sw   <= 1'b0;
    end else if (|next_trace_src) begin
      trace_vld  <= 1'b1;
      trace_src  <= next_trace_src;
      trace_addr <= next_taddr;
      trace_data <= next_tdata;
      trace_sw   <= 1'b0;
    end else if (sw_trace_req && sw_trace_en) begin
      trace_vld  <= 1'b1;
      trace_src  <= '0;
      trace_addr <= pc;
      trace_data <= sw_trace_data;
      trace_sw   <= 1'b1;
    end else begin
      trace_vld  <= 1'b0;
      trace_src  <= '0;
      trace_sw   <= 1'b0;
    end
  end

endmodule

// ### decu_top_sva.sv
// decu_top_sva: port-level checks of decu_top
// assumes: bound to decu_top, one clock, sync active-low reset
`timescale 1ns/1ps
module decu_top_sva
  import decu_pkg::*;
#(
  parameter int N  = NUM_CH,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic               clk,                  // clock
  input wire logic               nrst,                 // reset
  input wire logic               cpu_acc,              // cpu access
  input wire logic [AW-1:0]      cpu_addr,             // cpu address
  input wire logic               tlb_load_instruction, // tlb load
  input wire logic               sw_trace_req,         // sw request
  input wire logic [DW-1:0]      sw_trace_data,        // sw payload
  input wire logic               sw_trace_en,          // sw enable
  input wire logic               br_trace_dis,         // branch trace off
  input wire logic [N*QE_W-1:0]  ch_qual_en,           // enables
  input wire logic [N*2-1:0]     ch_action,            // actions
  input wire logic [N*AW-1:0]    ch_addr,              // addresses
  input wire logic               brk,                  // break
  input wire logic [N-1:0]       brk_src,              // break source
  input wire logic               trace_vld,            // trace entry
  input wire logic [N-1:0]       trace_src,            // trace source
  input wire logic [DW-1:0]      trace_data,           // trace data
  input wire logic               trace_sw,             // sw entry
  input wire logic               perf_start,           // perf start
  input wire logic               perf_end,             // perf end
  input wire logic               br_trace_on           // branch trace on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ====================================
  // assertions
  a_reset_clear: assert property (disable iff (1'b0) !nrst |=>
    !brk && !trace_vld && !perf_start && !perf_end && br_trace_on) else $error("outputs not cleared by reset");
  a_addr_break: assert property (cpu_acc && ch_qual_en[7:0] == 8'h01 && ch_action[1:0] == 2'h0
    && cpu_addr == ch_addr[AW-1:0] |=> brk && brk_src[0]) else $error("address match gave no break");
  a_tlb_forced_break: assert property (tlb_load_instruction && ch_qual_en[CH_TLB*QE_W+QE_TLB]
    |=> brk && brk_src[CH_TLB] && !trace_src[CH_TLB]) else $error("tlb load gave no break");
  a_idle_quiet: assert property (ch_qual_en == '0 |=> !brk && !perf_start && !perf_end)
    else $error("event without enabled channel");
  a_sw_source: assert property (trace_vld && trace_sw |-> $past(sw_trace_req && sw_trace_en))
    else $error("sw entry without enabled request");
  a_sw_entry: assert property (sw_trace_req && sw_trace_en && ch_qual_en == '0 |=>
    trace_vld && trace_sw && trace_data == $past(sw_trace_data)) else $error("sw entry lost");
  a_br_trace_off: assert property (br_trace_dis |=> !br_trace_on)
    else $error("branch trace stays on");
  a_trace_caps: assert property (trace_vld |-> trace_src[3:0] == 4'h0 && !trace_src[6]
    && trace_src[10:8] == 3'h0) else $error("trace from channel without trace");
  a_branch_gate: assert property (trace_vld && trace_src[CH_BRANCH] |-> $past(br_trace_on))
    else $error("branch trace while off");

  c_brk: cover property (brk);
  c_sw: cover property (trace_vld && trace_sw);
  c_ch_trace: cover property (trace_vld && trace_src[4]);
  c_perf: cover property (perf_end);
endmodule

bind decu_top decu_top_sva #(.N(N), .AW(AW), .DW(DW)) i_sva (
  .clk, .nrst, .cpu_acc, .cpu_addr, .tlb_load_instruction, .sw_trace_req, .sw_trace_data,
  .sw_trace_en, .br_trace_dis, .ch_qual_en, .ch_action, .ch_addr, .brk, .brk_src, .trace_vld,
  .trace_src, .trace_data, .trace_sw, .perf_start, .perf_end, .br_trace_on
);

// ### decu_top_tb.sv
// decu_top_tb: directed scenarios for decu_top
// assumes: decu_cpu_model drives the observed buses
`timescale 1ns/1ps
module decu_top_tb
  import decu_pkg::*;
();
  localparam logic [31:0] A = 32'h8000_1000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [NUM_CH*QE_W-1:0] ch_qual_en = '0;
  logic [NUM_CH*2-1:0] ch_action = '0, ch_size = '0;
  logic [NUM_CH*ADDR_W-1:0] ch_addr = '0, ch_addr_hi = '0;
  logic [NUM_CH*DATA_W-1:0] ch_data = '0;
  logic [NUM_CH-1:0] ch_rw_write = '0, ch_cnt_en = '0, brk_src, trace_src;
  logic [NUM_CH*CNT_W-1:0] ch_cnt = '0;
  logic br_trace_dis = 1'b0, sw_trace_en = 1'b0, sw_trace_req = 1'b0;
  logic [DATA_W-1:0] sw_trace_data = '0, cpu_data, sys_data, trace_data;
  logic [ADDR_W-1:0] cpu_addr, pc, sys_addr, branch_src, branch_dst, xbus_addr, ybus_addr, trace_addr;
  logic cpu_acc, cpu_write, ifetch, sys_acc, tlb_load_instruction, branch, xbus_acc, ybus_acc;
  logic brk, trace_vld, trace_sw, perf_start, perf_end, br_trace_on;
  int fails = 0, checks_done = 0, cycles = 0;

  always #12.5 clk = ~clk;

  decu_cpu_model i_cpu (.clk, .cpu_acc, .cpu_addr, .cpu_data, .cpu_write, .ifetch, .pc, .sys_acc,
    .sys_addr, .sys_data, .tlb_load_instruction, .branch, .branch_src, .branch_dst, .xbus_acc, .xbus_addr,
    .ybus_acc, .ybus_addr);

  decu_top i_dut (.clk, .nrst, .cpu_acc, .cpu_addr, .cpu_data, .cpu_write, .ifetch, .pc,
    .xbus_acc, .xbus_addr, .ybus_acc, .ybus_addr, .sys_acc, .sys_addr,
    .sys_data, .tlb_load_instruction, .branch, .branch_src, .branch_dst, .sw_trace_req,
    .sw_trace_data, .ch_qual_en, .ch_action, .ch_addr, .ch_addr_hi, .ch_data, .ch_size, .ch_rw_write,
    .ch_cnt_en, .ch_cnt, .br_trace_dis, .sw_trace_en, .brk, .brk_src, .trace_vld, .trace_src,
    .trace_addr, .trace_data, .trace_sw, .perf_start, .perf_end, .br_trace_on);

  // ====================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one channel enabled, others cleared
  task automatic cfg(input int c, input logic [7:0] q, input logic [1:0] act, input logic [31:0] a);
    @(negedge clk);
    ch_qual_en = (NUM_CH*QE_W)'(q) << (c * QE_W);
    ch_action = (NUM_CH*2)'(act) << (c * 2);
    ch_addr = (NUM_CH*ADDR_W)'(a) << (c * ADDR_W);
  endtask

  task automatic out(input logic [NUM_CH-1:0] bs, input logic [NUM_CH-1:0] ts);
    chk(brk, |bs);
    if (|bs) begin
      chk(brk_src, bs);
    end
    chk(trace_vld, |ts);
    if (|ts) begin
      chk(trace_src, ts);
    end
  endtask

  // ====================================
  // scenarios
  task automatic t_addr();
    cfg(0, 8'h01, 2'h0, A);
    i_cpu.op(0, A, 32'h0, 1'b0);
    out(12'h001, 12'h000);
    i_cpu.op(1, A, 32'h0, 1'b0);
    out(12'h001, 12'h000);
    i_cpu.op(0, A + 4, 32'h0, 1'b0);
    out(12'h000, 12'h000);
    for (int a = 1; a < 4; a++) begin
      cfg(0, 8'h01, 2'(a), A);
      i_cpu.op(0, A, 32'h0, 1'b0);
      chk({brk, trace_vld, perf_start, perf_end}, {2'h0, a == 2, a == 3});
    end
  endtask

  task automatic t_data();
    cfg(0, 8'h03, 2'h0, A);
    ch_data = (NUM_CH*DATA_W)'(32'h1234_5678);
    for (int s = 0; s < 3; s++) begin
      @(negedge clk);
      ch_size = (NUM_CH*2)'(s);
      i_cpu.op(0, A, 32'hAA55_5678, 1'b0);
      out((s < 2) ? 12'h001 : 12'h000, 12'h000);
    end
    i_cpu.op(0, A + 4, 32'h1234_5678, 1'b0);
    out(12'h000, 12'h000);
  endtask

  task automatic t_window();
    cfg(4, 8'h18, 2'h1, 32'h0000_2000);
    ch_addr_hi = (NUM_CH*ADDR_W)'(32'h0000_20FF) << (4 * ADDR_W);
    ch_rw_write = 12'h010;
    i_cpu.op(0, 32'h0000_20FF, 32'h1, 1'b1);
    out(12'h000, 12'h010);
    chk(trace_addr, 32'h0000_20FF);
    i_cpu.op(0, 32'h0000_2100, 32'h1, 1'b1);
    out(12'h000, 12'h000);
    i_cpu.op(0, 32'h0000_2000, 32'h1, 1'b0);
    out(12'h000, 12'h000);
    i_cpu.op(0, 32'h0000_2000, 32'h1, 1'b1);
    out(12'h000, 12'h010);
  endtask

  task automatic t_sys_tlb();
    cfg(7, 8'h20, 2'h0, 32'h4000_0010);
    ch_data = '0;
    i_cpu.op(2, 32'h4000_0010, 32'hFFFF_FFFF, 1'b0);
    out(12'h080, 12'h000);
    i_cpu.op(2, 32'h4000_0014, 32'hFFFF_FFFF, 1'b0);
    out(12'h000, 12'h000);
    cfg(7, 8'h20, 2'h1, 32'h4000_0010);
    i_cpu.op(2, 32'h4000_0010, 32'h0000_0055, 1'b0);
    out(12'h000, 12'h080);
    chk(trace_data, 32'h0000_0055);
    cfg(CH_TLB, 8'h40, 2'h1, 32'h0);
    i_cpu.op(3, 32'h0, 32'h0, 1'b0);
    out(12'h040, 12'h000);
  endtask

  task automatic t_bus();
    cfg(5, 8'h04, 2'h0, 32'h0000_3000);
    i_cpu.op(5, 32'h0000_3000, 32'h1, 1'b0);
    out(12'h020, 12'h000);
    i_cpu.op(6, 32'h0000_3000, 32'h1, 1'b0);
    out(12'h020, 12'h000);
    i_cpu.op(5, 32'h0000_3004, 32'h1, 1'b0);
    out(12'h000, 12'h000);
    i_cpu.op(0, 32'h0000_0000, 32'h0000_0100, 1'b0);
    out(12'h020, 12'h000);
  endtask

  task automatic t_count();
    cfg(1, 8'h01, 2'h0, A);
    ch_cnt_en = 12'h002;
    ch_cnt = (NUM_CH*CNT_W)'(16'h0003) << CNT_W;
    for (int i = 1; i < 7; i++) begin
      i_cpu.op(0, A, 32'h0, 1'b0);
      out((i % 3 == 0) ? 12'h002 : 12'h000, 12'h000);
    end
  endtask

  task automatic t_branch();
    cfg(CH_BRANCH, 8'h80, 2'h1, 32'h0);
    i_cpu.op(4, 32'h0000_1234, 32'h0, 1'b0);
    out(12'h000, 12'h800);
    chk(trace_addr, 32'h0000_1234);
    br_trace_dis = 1'b1;
    i_cpu.op(4, 32'h0000_1234, 32'h0, 1'b0);
    out(12'h000, 12'h000);
    chk(br_trace_on, 1'b0);
    br_trace_dis = 1'b0;
  endtask

  task automatic t_sw();
    cfg(0, 8'h00, 2'h0, 32'h0);
    for (int e = 0; e < 2; e++) begin
      @(negedge clk);
      sw_trace_en = e[0];
      sw_trace_req = 1'b1;
      sw_trace_data = 32'hC0DE_0000 + e;
      @(negedge clk);
      sw_trace_req = 1'b0;
      chk({trace_vld, trace_sw}, {e[0], e[0]});
    end
    chk(trace_data, 32'hC0DE_0001);
  endtask

  // ====================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 1000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    chk({brk, trace_vld, perf_start, perf_end, br_trace_on}, 5'h01);
    t_addr();
    t_data();
    t_window();
    t_sys_tlb();
    t_bus();
    t_count();
    t_branch();
    t_sw();
    final_report();
  end
endmodule

// ### decu_window.sv
// decu_window: inclusive address range compare
// assumes: lo not above hi when enabled
`timescale 1ns/1ps
module decu_window
  import decu_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic [AW-1:0] addr, // observed address
  input  wire logic [AW-1:0] lo,   // window low bound
  input  wire logic [AW-1:0] hi,   // window high bound
  output logic               hit   // address inside window
);

  assign hit = (addr >= lo) && (addr <= hi);

endmodule
